/* pkg/dccr_pkg.sv */
// Constants and types shared by the channel configuration register bank.
package dccr_pkg;

  localparam int NUM_CH = 2;
  localparam int NUM_KIND = 4;
  localparam int DATA_W = 16;
  localparam int CODE_W = 12;
  localparam int WAVE_W = 13;

  localparam logic [15:0] REG_RESET = 16'h0000;

  // Register addresses on the serial host interface.
  localparam logic [7:0] ADDR_A_VOUT = 8'h03;
  localparam logic [7:0] ADDR_A_IOUT = 8'h04;
  localparam logic [7:0] ADDR_A_CMP = 8'h05;
  localparam logic [7:0] ADDR_A_FUNC = 8'h06;
  localparam logic [7:0] ADDR_B_VOUT = 8'h15;
  localparam logic [7:0] ADDR_B_IOUT = 8'h16;
  localparam logic [7:0] ADDR_B_CMP = 8'h17;
  localparam logic [7:0] ADDR_B_FUNC = 8'h18;

  // Page and command codes for the PMBus view.
  localparam logic [7:0] PMB_PAGE = 8'hff;
  localparam logic [7:0] PMB_A_VOUT = 8'hd1;
  localparam logic [7:0] PMB_A_IOUT = 8'hd2;
  localparam logic [7:0] PMB_A_CMP = 8'hd3;
  localparam logic [7:0] PMB_A_FUNC = 8'hd4;
  localparam logic [7:0] PMB_B_VOUT = 8'hdd;
  localparam logic [7:0] PMB_B_IOUT = 8'hde;
  localparam logic [7:0] PMB_B_CMP = 8'hdf;
  localparam logic [7:0] PMB_B_FUNC = 8'he0;

  // Register kinds within one channel.
  localparam logic [1:0] KIND_VOUT = 2'h0;
  localparam logic [1:0] KIND_IOUT = 2'h1;
  localparam logic [1:0] KIND_CMP = 2'h2;
  localparam logic [1:0] KIND_FUNC = 2'h3;

  // Writable bits of each kind; all others are don't care.
  localparam logic [15:0] MASK_VOUT = 16'h1c1f;
  localparam logic [15:0] MASK_IOUT = 16'h1e00;
  localparam logic [15:0] MASK_CMP = 16'h0c00;
  localparam logic [15:0] MASK_FUNC = 16'hffff;

  // Field positions.
  localparam int GAIN_LSB = 10;
  localparam int OD_BIT = 4;
  localparam int ROUTE_BIT = 3;
  localparam int DIV_BIT = 2;
  localparam int INV_BIT = 1;
  localparam int CMP_EN_BIT = 0;
  localparam int IRANGE_LSB = 9;
  localparam int CMODE_LSB = 10;
  localparam int CLR_BIT = 15;
  localparam int SYNC_BIT = 14;
  localparam int BRD_BIT = 13;

  // Voltage gain codes.
  localparam logic [2:0] GAIN_EXT_1X = 3'h0;
  localparam logic [2:0] GAIN_VDD_1X = 3'h1;
  localparam logic [2:0] GAIN_INT_1P5X = 3'h2;
  localparam logic [2:0] GAIN_INT_2X = 3'h3;
  localparam logic [2:0] GAIN_INT_3X = 3'h4;
  localparam logic [2:0] GAIN_INT_4X = 3'h5;

  // Current range codes.
  localparam logic [3:0] IRANGE_25UA = 4'h8;
  localparam logic [3:0] IRANGE_50UA = 4'h9;
  localparam logic [3:0] IRANGE_125UA = 4'ha;
  localparam logic [3:0] IRANGE_250UA = 4'hb;

  // Clear levels.
  localparam logic [11:0] ZERO_SCALE = 12'h000;
  localparam logic [11:0] MID_SCALE = 12'h800;

  typedef enum logic [1:0] {
    DCCR_REF_EXT = 2'b00,
    DCCR_REF_VDD = 2'b01,
    DCCR_REF_INT = 2'b10,
    DCCR_REF_NONE = 2'b11
  } dccr_ref_e;

  typedef enum logic [1:0] {
    DCCR_CMP_PLAIN = 2'b00,
    DCCR_CMP_HYST = 2'b01,
    DCCR_CMP_WINDOW = 2'b10,
    DCCR_CMP_BAD = 2'b11
  } dccr_cmp_mode_e;

endpackage

/* hdl/dccr_update.sv */
// Output code update control for one channel: clear, sync and broadcast.
module dccr_update
  import dccr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clr_level,
  input wire logic sync_sel,
  input wire logic brd_sel,
  input wire logic wr_valid,
  input wire logic [CODE_W-1:0] wr_code,
  input wire logic bcast_valid,
  input wire logic [CODE_W-1:0] bcast_code,
  input wire logic load_trigger_pin,
  input wire logic trig_load,
  input wire logic clear_req,
  output logic [CODE_W-1:0] out_code
);

  logic [CODE_W-1:0] staged_reg, staged_next;
  logic [CODE_W-1:0] active_reg, active_next;
  logic load_prev_reg, load_prev_next;
  logic load_fall;
  logic take;
  logic [CODE_W-1:0] take_code;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    load_prev_next = load_trigger_pin;
    load_fall = load_prev_reg & ~load_trigger_pin;
    take = wr_valid | (bcast_valid & brd_sel);
    take_code = wr_valid ? wr_code : bcast_code;
    staged_next = take ? take_code : staged_reg;
    active_next = active_reg;
    if (!sync_sel && take) begin
      active_next = take_code;
    end else if (sync_sel && (load_fall || trig_load)) begin
      active_next = staged_next;
    end
    if (clear_req) begin
      active_next = clr_level ? MID_SCALE : ZERO_SCALE;
    end
  end

  // The load pin idles high, so the history flop resets high to avoid a false edge.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      staged_reg <= ZERO_SCALE;
      active_reg <= ZERO_SCALE;
      load_prev_reg <= 1'b1;
    end else begin
      staged_reg <= staged_next;
      active_reg <= active_next;
      load_prev_reg <= load_prev_next;
    end
  end

  assign out_code = active_reg;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_sync_held;
    sync_sel && !clear_req && !trig_load && !(load_prev_reg && !load_trigger_pin);
  endsequence

  chk_clear_level: assert property (clear_req |=> out_code == ($past(clr_level) ? MID_SCALE : ZERO_SCALE))
    else $error("clear did not reach the selected level");
  chk_sync_hold: assert property (s_sync_held |=> $stable(out_code))
    else $error("output moved without a load event in sync mode");
  chk_direct_write: assert property (wr_valid && !sync_sel && !clear_req |=> out_code == $past(wr_code))
    else $error("write did not update the output at once");
  chk_bcast_ignore: assert property (bcast_valid && !brd_sel && !wr_valid |=> $stable(staged_reg))
    else $error("broadcast taken by a non participating channel");

endmodule // dccr_update

/* hdl/dccr_regs.sv */
// Per-channel configuration register bank of the dual output converter.
module dccr_regs
  import dccr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_pmbus,
  input wire logic [7:0] req_page,
  input wire logic [7:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic rsp_valid,
  output logic rsp_hit,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic [NUM_CH-1:0][2:0] gain_code,
  output dccr_ref_e [NUM_CH-1:0] ref_sel,
  output logic [NUM_CH-1:0] gain_valid,
  output logic [NUM_CH-1:0] cmp_enable,
  output logic [NUM_CH-1:0] cmp_invert,
  output logic [NUM_CH-1:0] fb_divider_on,
  output logic [NUM_CH-1:0] cmp_route,
  output logic [NUM_CH-1:0][3:0] current_range,
  output logic [NUM_CH-1:0] current_range_valid,
  output dccr_cmp_mode_e [NUM_CH-1:0] cmp_mode,
  output logic [NUM_CH-1:0] cmp_mode_valid,
  output logic [NUM_CH-1:0][WAVE_W-1:0] wave_block,
  input wire logic [NUM_CH-1:0] cmp_raw,
  output logic [NUM_CH-1:0] cmp_result,
  output logic [NUM_CH-1:0] out_pin_o,
  output logic [NUM_CH-1:0] out_pin_oe,
  input wire logic [NUM_CH-1:0] dac_wr_valid,
  input wire logic [NUM_CH-1:0][CODE_W-1:0] dac_wr_code,
  input wire logic bcast_valid,
  input wire logic [CODE_W-1:0] bcast_code,
  input wire logic load_trigger_pin,
  input wire logic trig_load,
  input wire logic clear_req,
  output logic [NUM_CH-1:0][CODE_W-1:0] dac_code
);

  ////////////////////////////////////////////////////////////////////////////
  // Returns {hit, channel, kind[1:0]} for a request.
  function automatic logic [3:0] dccr_decode(input logic pmbus, input logic [7:0] page, input logic [7:0] addr);
    logic [3:0] res;
    res = 4'h0;
    if (pmbus) begin
      if (page == PMB_PAGE) begin
        case (addr)
          PMB_A_VOUT: res = {2'b10, KIND_VOUT};
          PMB_A_IOUT: res = {2'b10, KIND_IOUT};
          PMB_A_CMP: res = {2'b10, KIND_CMP};
          PMB_A_FUNC: res = {2'b10, KIND_FUNC};
          PMB_B_VOUT: res = {2'b11, KIND_VOUT};
          PMB_B_IOUT: res = {2'b11, KIND_IOUT};
          PMB_B_CMP: res = {2'b11, KIND_CMP};
          PMB_B_FUNC: res = {2'b11, KIND_FUNC};
          default: res = 4'h0;
        endcase
      end
    end else begin
      case (addr)
        ADDR_A_VOUT: res = {2'b10, KIND_VOUT};
        ADDR_A_IOUT: res = {2'b10, KIND_IOUT};
        ADDR_A_CMP: res = {2'b10, KIND_CMP};
        ADDR_A_FUNC: res = {2'b10, KIND_FUNC};
        ADDR_B_VOUT: res = {2'b11, KIND_VOUT};
        ADDR_B_IOUT: res = {2'b11, KIND_IOUT};
        ADDR_B_CMP: res = {2'b11, KIND_CMP};
        ADDR_B_FUNC: res = {2'b11, KIND_FUNC};
        default: res = 4'h0;
      endcase
    end
    return res;
  endfunction

  function automatic logic [15:0] dccr_mask(input logic [1:0] kind);
    logic [15:0] m;
    case (kind)
      KIND_VOUT: m = MASK_VOUT;
      KIND_IOUT: m = MASK_IOUT;
      KIND_CMP: m = MASK_CMP;
      default: m = MASK_FUNC;
    endcase
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register storage and host access.
  logic [NUM_CH-1:0][NUM_KIND-1:0][DATA_W-1:0] cfg_reg, cfg_next;
  logic rsp_valid_reg, rsp_valid_next;
  logic rsp_hit_reg, rsp_hit_next;
  logic [DATA_W-1:0] rsp_rdata_reg, rsp_rdata_next;
  logic [3:0] dec;

  always_comb begin
    dec = dccr_decode(req_pmbus, req_page, req_addr);
    cfg_next = cfg_reg;
    rsp_valid_next = req_valid;
    rsp_hit_next = req_valid & dec[3];
    rsp_rdata_next = '0;
    if (req_valid && dec[3]) begin
      if (req_write) begin
        cfg_next[dec[2]][dec[1:0]] = req_wdata & dccr_mask(dec[1:0]);
      end else begin
        rsp_rdata_next = cfg_reg[dec[2]][dec[1:0]];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < NUM_CH; c++) begin
        for (int k = 0; k < NUM_KIND; k++) begin
          cfg_reg[c][k] <= REG_RESET;
        end
      end
      rsp_valid_reg <= 1'b0;
      rsp_hit_reg <= 1'b0;
      rsp_rdata_reg <= REG_RESET;
    end else begin
      cfg_reg <= cfg_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_hit_reg <= rsp_hit_next;
      rsp_rdata_reg <= rsp_rdata_next;
    end
  end

  assign rsp_valid = rsp_valid_reg;
  assign rsp_hit = rsp_hit_reg;
  assign rsp_rdata = rsp_rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_pmbus_wrong_page: assert property (req_valid && req_pmbus && req_page != PMB_PAGE |=> !rsp_hit)
    else $error("PMBus access off the register page was accepted");
  chk_dontcare_read: assert property (req_valid && !req_write && !req_pmbus && req_addr == ADDR_A_IOUT
      |=> rsp_hit && (rsp_rdata & ~MASK_IOUT) == 16'h0000)
    else $error("don't care bits read back as nonzero");

  ////////////////////////////////////////////////////////////////////////////
  // Decoded per-channel controls, comparator path and output update.
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    logic [DATA_W-1:0] vcfg, icfg, mcfg, fcfg;
    logic [2:0] gain_next;
    dccr_ref_e ref_next;
    logic gain_ok_next;
    logic [3:0] range_next;
    logic range_ok_next;
    logic mode_ok_next;
    logic [WAVE_W-1:0] wave_next;
    dccr_cmp_mode_e mode_next;
    logic en_next, inv_next, div_next, route_next, od_active;
    logic res_next, pin_o_next, pin_oe_next;
    logic [2:0] gain_reg;
    dccr_ref_e ref_reg;
    logic gain_ok_reg, range_ok_reg, mode_ok_reg;
    logic [3:0] range_reg;
    dccr_cmp_mode_e mode_reg;
    logic en_reg, inv_reg, div_reg, route_reg, res_reg, pin_o_reg, pin_oe_reg;
    logic [WAVE_W-1:0] wave_reg;

    always_comb begin
      vcfg = cfg_reg[ch][KIND_VOUT];
      icfg = cfg_reg[ch][KIND_IOUT];
      mcfg = cfg_reg[ch][KIND_CMP];
      fcfg = cfg_reg[ch][KIND_FUNC];
      gain_next = vcfg[GAIN_LSB +: 3];
      case (gain_next)
        GAIN_EXT_1X: ref_next = DCCR_REF_EXT;
        GAIN_VDD_1X: ref_next = DCCR_REF_VDD;
        GAIN_INT_1P5X, GAIN_INT_2X, GAIN_INT_3X, GAIN_INT_4X: ref_next = DCCR_REF_INT;
        default: ref_next = DCCR_REF_NONE;
      endcase
      gain_ok_next = (ref_next != DCCR_REF_NONE);
      range_next = icfg[IRANGE_LSB +: 4];
      case (range_next)
        IRANGE_25UA, IRANGE_50UA, IRANGE_125UA, IRANGE_250UA: range_ok_next = 1'b1;
        default: range_ok_next = 1'b0;
      endcase
      mode_next = dccr_cmp_mode_e'(mcfg[CMODE_LSB +: 2]);
      mode_ok_next = (mode_next != DCCR_CMP_BAD);
      wave_next = fcfg[WAVE_W-1:0];
      en_next = vcfg[CMP_EN_BIT];
      inv_next = vcfg[INV_BIT];
      div_next = vcfg[DIV_BIT];
      route_next = vcfg[ROUTE_BIT];
      // optional inversion, result only in comparator mode
      res_next = en_next & (cmp_raw[ch] ^ inv_next);
      // open drain only with comparator routed
      od_active = vcfg[OD_BIT] & en_next & route_next;
      if (en_next && route_next) begin
        pin_o_next = od_active ? 1'b0 : res_next;
        pin_oe_next = od_active ? ~res_next : 1'b1;
      end else begin
        pin_o_next = 1'b0;
        pin_oe_next = 1'b0;
      end
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        gain_reg <= GAIN_EXT_1X;
        ref_reg <= DCCR_REF_EXT;
        gain_ok_reg <= 1'b1;
        range_reg <= 4'h0;
        range_ok_reg <= 1'b0;
        mode_reg <= DCCR_CMP_PLAIN;
        mode_ok_reg <= 1'b1;
        en_reg <= 1'b0;
        inv_reg <= 1'b0;
        div_reg <= 1'b0;
        route_reg <= 1'b0;
        res_reg <= 1'b0;
        pin_o_reg <= 1'b0;
        pin_oe_reg <= 1'b0;
        wave_reg <= '0;
      end else begin
        gain_reg <= gain_next;
        ref_reg <= ref_next;
        gain_ok_reg <= gain_ok_next;
        range_reg <= range_next;
        range_ok_reg <= range_ok_next;
        mode_reg <= mode_next;
        mode_ok_reg <= mode_ok_next;
        en_reg <= en_next;
        inv_reg <= inv_next;
        div_reg <= div_next;
        route_reg <= route_next;
        res_reg <= res_next;
        pin_o_reg <= pin_o_next;
        pin_oe_reg <= pin_oe_next;
        wave_reg <= wave_next;
      end
    end

    assign gain_code[ch] = gain_reg;
    assign ref_sel[ch] = ref_reg;
    assign gain_valid[ch] = gain_ok_reg;
    assign current_range[ch] = range_reg;
    assign current_range_valid[ch] = range_ok_reg;
    assign cmp_mode[ch] = mode_reg;
    assign cmp_mode_valid[ch] = mode_ok_reg;
    assign cmp_enable[ch] = en_reg;
    assign cmp_invert[ch] = inv_reg;
    assign fb_divider_on[ch] = div_reg;
    assign cmp_route[ch] = route_reg;
    assign cmp_result[ch] = res_reg;
    assign out_pin_o[ch] = pin_o_reg;
    assign out_pin_oe[ch] = pin_oe_reg;
    assign wave_block[ch] = wave_reg;

    // clear, sync and broadcast bits steer the update
    // participation passed to update control
    // The host must keep the current output powered down in comparator mode; nothing here enforces it.
    dccr_update u_update (
      .clk(clk),
      .rst(rst),
      .clr_level(fcfg[CLR_BIT]),
      .sync_sel(fcfg[SYNC_BIT]),
      .brd_sel(fcfg[BRD_BIT]),
      .wr_valid(dac_wr_valid[ch]),
      .wr_code(dac_wr_code[ch]),
      .bcast_valid(bcast_valid),
      .bcast_code(bcast_code),
      .load_trigger_pin(load_trigger_pin),
      .trig_load(trig_load),
      .clear_req(clear_req),
      .out_code(dac_code[ch])
    );

    sequence s_cfg_write(logic [1:0] k);
      req_valid && req_write && dec[3] && dec[2] == ch && dec[1:0] == k;
    endsequence

    chk_gain_decode: assert property (gain_valid[ch] == (gain_code[ch] <= GAIN_INT_4X))
      else $error("gain validity disagrees with code");
    chk_od_pin: assert property (cmp_enable[ch] && cmp_route[ch] && $past(cfg_reg[ch][KIND_VOUT][OD_BIT])
      |-> !out_pin_o[ch] && out_pin_oe[ch] == !cmp_result[ch])
      else $error("open-drain pin drive wrong");
    chk_route_pin: assert property (cmp_enable[ch] && cmp_route[ch] && out_pin_oe[ch] |-> out_pin_o[ch] == cmp_result[ch]
      || out_pin_o[ch] == 1'b0)
      else $error("routed pin does not follow comparator");
    chk_divider_cfg: assert property (s_cfg_write(KIND_VOUT) ##1 1'b1 |=> fb_divider_on[ch] == $past(req_wdata[DIV_BIT], 2))
      else $error("divider control did not follow write");
    chk_invert_res: assert property (cmp_enable[ch] |=>
      cmp_result[ch] == ($past(cmp_raw[ch]) ^ $past(cfg_reg[ch][KIND_VOUT][INV_BIT])) ||
      $past(cmp_enable[ch]) != $past(cfg_reg[ch][KIND_VOUT][CMP_EN_BIT]))
      else $error("comparator result inversion wrong");
    chk_cmp_off: assert property (!cmp_enable[ch] |-> !cmp_result[ch] && !out_pin_oe[ch])
      else $error("comparator active while disabled");
    chk_range_decode: assert property (current_range_valid[ch] == (current_range[ch] inside {[IRANGE_25UA:IRANGE_250UA]}))
      else $error("current range validity wrong");
    chk_mode_valid: assert property (cmp_mode_valid[ch] == (cmp_mode[ch] != DCCR_CMP_BAD))
      else $error("comparator mode validity wrong");
    chk_mode_write: assert property (s_cfg_write(KIND_CMP) ##2 1'b1 |-> cmp_mode[ch] == $past(req_wdata[11:10], 2))
      else $error("comparator mode did not follow write");
    chk_write_mask: assert property (s_cfg_write(KIND_VOUT) |=> cfg_reg[ch][KIND_VOUT] == ($past(req_wdata) & MASK_VOUT))
      else $error("don't care bits were stored");
  end

endmodule // dccr_regs

/* testbench/dccr_host_model.sv */
// Host controller model that issues register requests to the bank.
module dccr_host_model
  import dccr_pkg::*;
(
  input wire logic clk,
  output logic req_valid,
  output logic req_write,
  output logic req_pmbus,
  output logic [7:0] req_page,
  output logic [7:0] req_addr,
  output logic [DATA_W-1:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic rsp_hit,
  input wire logic [DATA_W-1:0] rsp_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_pmbus = 1'b0;
    req_page = 8'h00;
    req_addr = 8'h00;
    req_wdata = 16'h0000;
  end
  ////////////////////////////////////////
  // page and command code per request.
  task automatic access(input logic wr, input logic pmb, input logic [7:0] pg, input logic [7:0] a,
    input logic [15:0] wd, output logic [15:0] rd, output logic hit, output logic ok);
    @(posedge clk);
    #2;
    req_valid = 1'b1;
    req_write = wr;
    req_pmbus = pmb;
    req_page = pg;
    req_addr = a;
    req_wdata = wd;
    @(posedge clk);
    #2;
    // Released page, address and data lines flip, so a late sample cannot pass on the old value.
    req_valid = 1'b0;
    req_page = ~pg;
    req_addr = ~a;
    req_wdata = ~wd;
    ok = rsp_valid;
    rd = rsp_rdata;
    hit = rsp_hit;
  endtask
endmodule // dccr_host_model

/* testbench/dccr_regs_tb_top.sv */
// Self-checking bench for the channel configuration register bank.
module dccr_regs_tb_top
  import dccr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, req_valid, req_write, req_pmbus, rsp_valid, rsp_hit;
  logic [7:0] req_page, req_addr;
  logic [DATA_W-1:0] req_wdata, rsp_rdata;
  logic [NUM_CH-1:0][2:0] gain_code;
  dccr_ref_e [NUM_CH-1:0] ref_sel;
  dccr_cmp_mode_e [NUM_CH-1:0] cmp_mode;
  logic [NUM_CH-1:0] gain_valid, cmp_enable, cmp_invert, fb_divider_on, cmp_route, current_range_valid;
  logic [NUM_CH-1:0] cmp_mode_valid, cmp_raw, cmp_result, out_pin_o, out_pin_oe, dac_wr_valid;
  logic [NUM_CH-1:0][3:0] current_range;
  logic [NUM_CH-1:0][WAVE_W-1:0] wave_block;
  logic [NUM_CH-1:0][CODE_W-1:0] dac_wr_code, dac_code;
  logic bcast_valid, load_trigger_pin, trig_load, clear_req;
  logic [CODE_W-1:0] bcast_code;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] addr_t [8] = '{ADDR_A_VOUT, ADDR_A_IOUT, ADDR_A_CMP, ADDR_A_FUNC,
    ADDR_B_VOUT, ADDR_B_IOUT, ADDR_B_CMP, ADDR_B_FUNC};
  logic [7:0] cmd_t [8] = '{PMB_A_VOUT, PMB_A_IOUT, PMB_A_CMP, PMB_A_FUNC,
    PMB_B_VOUT, PMB_B_IOUT, PMB_B_CMP, PMB_B_FUNC};
  logic [15:0] mask_t [4] = '{MASK_VOUT, MASK_IOUT, MASK_CMP, MASK_FUNC};

  dccr_host_model host (.clk, .req_valid, .req_write, .req_pmbus, .req_page, .req_addr, .req_wdata,
    .rsp_valid, .rsp_hit, .rsp_rdata);
  dccr_regs DUT (.clk, .rst, .req_valid, .req_write, .req_pmbus, .req_page, .req_addr, .req_wdata,
    .rsp_valid, .rsp_hit, .rsp_rdata, .gain_code, .ref_sel, .gain_valid, .cmp_enable, .cmp_invert,
    .fb_divider_on, .cmp_route, .current_range, .current_range_valid, .cmp_mode, .cmp_mode_valid,
    .wave_block, .cmp_raw, .cmp_result, .out_pin_o, .out_pin_oe, .dac_wr_valid, .dac_wr_code,
    .bcast_valid, .bcast_code, .load_trigger_pin, .trig_load, .clear_req, .dac_code);

  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end
  ////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic acc(input logic wr, input logic pmb, input logic [7:0] pg, input logic [7:0] a,
    input logic [15:0] wd, input logic [15:0] exp, input logic exp_hit);
    logic [15:0] rd;
    logic hit, ok;
    host.access(wr, pmb, pg, a, wd, rd, hit, ok);
    check("rsp_valid", {15'h0, ok}, 16'h0001);
    check("rsp_hit", {15'h0, hit}, {15'h0, exp_hit});
    check("rsp_rdata", rd, wr ? 16'h0000 : exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    acc(1'b1, 1'b0, 8'h00, a, d, 16'h0000, 1'b1);
  endtask

  // Three edges cover the register and its decoded copy.
  task automatic settle();
    repeat (3) @(posedge clk);
    #2;
  endtask

  task automatic upd(input int kind, input int ch, input logic [11:0] code);
    @(posedge clk);
    #2;
    case (kind)
      0: begin
        dac_wr_valid[ch] = 1'b1;
        dac_wr_code[ch] = code;
      end
      1: begin
        bcast_valid = 1'b1;
        bcast_code = code;
      end
      2: trig_load = 1'b1;
      3: load_trigger_pin = 1'b0;
      default: clear_req = 1'b1;
    endcase
    @(posedge clk);
    #2;
    dac_wr_valid = '0;
    bcast_valid = 1'b0;
    trig_load = 1'b0;
    load_trigger_pin = 1'b1;
    clear_req = 1'b0;
    settle();
  endtask
  ////////////////////////////////////////
  task automatic test_regs();
    for (int i = 0; i < 8; i++) begin
      acc(1'b0, 1'b0, 8'h00, addr_t[i], 16'h0, REG_RESET, 1'b1);
      acc(1'b1, 1'b1, PMB_PAGE, cmd_t[i], 16'hffff, 16'h0, 1'b1);
      acc(1'b0, 1'b0, 8'h00, addr_t[i], 16'h0, mask_t[i%4], 1'b1);
      acc(1'b1, 1'b1, 8'h00, cmd_t[i], 16'h0, 16'h0, 1'b0);
      acc(1'b0, 1'b1, PMB_PAGE, cmd_t[i], 16'h0, mask_t[i%4], 1'b1);
      if (i % 4 == 3) check("wave_block", 16'(wave_block[i/4]), 16'h1fff);
      wr(addr_t[i], 16'h0000);
    end
    acc(1'b0, 1'b0, 8'h00, 8'h07, 16'h0, 16'h0, 1'b0);
    $display("test registers done");
  endtask

  task automatic test_fields();
    for (int ch = 0; ch < 2; ch++) begin
      for (int c = 0; c < 16; c++) begin
        wr(addr_t[ch*4], 16'(c % 8) << GAIN_LSB);
        wr(addr_t[ch*4+1], 16'(c) << IRANGE_LSB);
        wr(addr_t[ch*4+2], 16'(c % 4) << CMODE_LSB);
        settle();
        check("gain_code", 16'(gain_code[ch]), 16'(c % 8));
        check("gain_valid", 16'(gain_valid[ch]), 16'(c % 8 <= 5));
        check("ref_sel", 16'(ref_sel[ch]), c % 8 == 0 ? 16'h0 : c % 8 == 1 ? 16'h1 : c % 8 <= 5 ? 16'h2 : 16'h3);
        check("current_range", 16'(current_range[ch]), 16'(c));
        check("range_valid", 16'(current_range_valid[ch]), 16'(c >= 8 && c <= 11));
        check("cmp_mode", 16'(cmp_mode[ch]), 16'(c % 4));
        check("cmp_mode_valid", 16'(cmp_mode_valid[ch]), 16'(c % 4 != 3));
      end
    end
    $display("test fields done");
  endtask

  task automatic test_cmp();
    logic [5:0] f;
    logic res, route;
    for (int ch = 0; ch < 2; ch++) begin
      wr(addr_t[ch*4+1], 16'h0000);
      for (int k = 0; k < 64; k++) begin
        f = 6'(k);
        cmp_raw[ch] = f[5];
        wr(addr_t[ch*4], {11'h0, f[4:0]});
        settle();
        res = f[0] & (f[5] ^ f[1]);
        route = f[0] & f[3];
        check("cmp_result", 16'(cmp_result[ch]), 16'(res));
        check("cmp_enable", 16'(cmp_enable[ch]), 16'(f[0]));
        check("cmp_invert", 16'(cmp_invert[ch]), 16'(f[1]));
        check("cmp_route", 16'(cmp_route[ch]), 16'(f[3]));
        check("fb_divider_on", 16'(fb_divider_on[ch]), 16'(f[2]));
        check("out_pin_oe", 16'(out_pin_oe[ch]), 16'(route & (f[4] ? ~res : 1'b1)));
        if (route) check("out_pin_o", 16'(out_pin_o[ch]), 16'(~f[4] & res));
      end
    end
    $display("test comparator done");
  endtask

  task automatic test_update();
    for (int ch = 0; ch < 2; ch++) begin
      wr(addr_t[ch*4+3], 16'h0000);
      upd(0, ch, 12'h123);
      check("dac_code", 16'(dac_code[ch]), 16'h0123);
      upd(1, ch, 12'h456);
      check("dac_code", 16'(dac_code[ch]), 16'h0123);
      wr(addr_t[ch*4+3], 16'h2000);
      upd(1, ch, 12'h456);
      check("dac_code", 16'(dac_code[ch]), 16'h0456);
      wr(addr_t[ch*4+3], 16'h4000);
      upd(0, ch, 12'h789);
      check("dac_code", 16'(dac_code[ch]), 16'h0456);
      upd(2, ch, 12'h0);
      check("dac_code", 16'(dac_code[ch]), 16'h0789);
      upd(0, ch, 12'habc);
      upd(3, ch, 12'h0);
      check("dac_code", 16'(dac_code[ch]), 16'h0abc);
      upd(4, ch, 12'h0);
      check("dac_code", 16'(dac_code[ch]), 16'(ZERO_SCALE));
      wr(addr_t[ch*4+3], 16'h8000);
      upd(4, ch, 12'h0);
      check("dac_code", 16'(dac_code[ch]), 16'(MID_SCALE));
    end
    $display("test update done");
  endtask

  task automatic finish_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    cmp_raw = '0;
    dac_wr_valid = '0;
    dac_wr_code = '0;
    bcast_valid = 1'b0;
    bcast_code = '0;
    load_trigger_pin = 1'b1;
    trig_load = 1'b0;
    clear_req = 1'b0;
    repeat (6) @(posedge clk);
    #2;
    rst = 1'b0;
    test_regs();
    test_fields();
    test_cmp();
    test_update();
    finish_test();
  end
endmodule // dccr_regs_tb_top
